// ===== hdl/wosr_options.sv
// Purpose: Write-once system options register with an AXI4-Lite slave port.
// Assumes: One clock, asynchronous active-high reset, inputs synchronous to sys_clk.
// Notes: Drives watchdog period select, stop handling and serial bus pin routing.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wosr_regs.svh"

// Overview of operation
// - Only the first options write after reset with byte lane 0 strobed sticks.
// - Register reads back current contents any time.
// - Bits 7:6 plus clock source choose timeout.
// - Bit 5 enables stop mode when set.
// - Stop while disabled forces illegal-opcode reset.
// - Bit 2 moves serial bus pins A to B.
module wosr_options #(
    parameter int ADDR_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    // AXI4-Lite write address, data and response.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Watchdog and stop control.
    input wire logic watchdog_clock_source_select,
    output logic [2:0] watchdog_period_select,
    input wire logic stop_exec,
    output logic stop_mode_enter,
    output logic illegal_opcode_reset,
    output logic stop_mode_enable,
    // Serial bus side of the pin routing.
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    output logic serial_data_in,
    output logic serial_clock_in,
    // Pins: port A lines two and three, port B lines six and seven.
    input wire logic port_a_line_two_in,
    output logic port_a_line_two_out,
    output logic port_a_line_two_oe,
    input wire logic port_a_line_three_in,
    output logic port_a_line_three_out,
    output logic port_a_line_three_oe,
    input wire logic port_b_line_six_in,
    output logic port_b_line_six_out,
    output logic port_b_line_six_oe,
    input wire logic port_b_line_seven_in,
    output logic port_b_line_seven_out,
    output logic port_b_line_seven_oe
);

    // ======================================================================
    // Parameter check
    generate
        if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
            $error("wosr_options: ADDR_W must lie between 3 and 8");
        end
    endgenerate

    // ======================================================================
    // Register state
    wosr_pkg::wosr_opts_s opts;
    wosr_pkg::wosr_opts_s next_opts;
    wosr_pkg::wosr_lock_e lock;
    wosr_pkg::wosr_lock_e next_lock;
    logic aw_full;
    logic next_aw_full;
    logic w_full;
    logic next_w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [7:0] w_byte;
    logic [7:0] next_w_byte;
    logic w_lane0;
    logic next_w_lane0;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // Word-aligned address match against a byte offset.
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        logic [7:0] wide;
        wide = 8'(addr);
        return wide[7:2] == off[7:2];
    endfunction : addr_is

    // Write channel: collects address and data in either order, then commits.
    always_comb begin
        logic aw_take;
        logic w_take;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic lane0;
        aw_take = s_axi_awvalid && s_axi_awready;
        w_take = s_axi_wvalid && s_axi_wready;
        addr = aw_full ? aw_addr : s_axi_awaddr;
        data = w_full ? w_byte : s_axi_wdata[7:0];
        lane0 = w_full ? w_lane0 : s_axi_wstrb[0];
        next_opts = opts;
        next_lock = lock;
        next_aw_full = aw_full || aw_take;
        next_w_full = w_full || w_take;
        next_aw_addr = aw_take ? s_axi_awaddr : aw_addr;
        next_w_byte = w_take ? s_axi_wdata[7:0] : w_byte;
        next_w_lane0 = w_take ? s_axi_wstrb[0] : w_lane0;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (next_aw_full && next_w_full && !s_axi_bvalid) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `WOSR_RESP_OKAY;
            if (addr_is(addr, `WOSR_OPTS_OFFSET)) begin
                if (lock == wosr_pkg::WOSR_OPEN && lane0) begin
                    next_opts = wosr_pkg::wosr_opts_s'(data & `WOSR_OPTS_IMPL_MASK);
                    next_lock = wosr_pkg::WOSR_LOCKED;
                end
            end else if (!addr_is(addr, `WOSR_STATUS_OFFSET)) begin
                next_bresp = `WOSR_RESP_SLVERR;
            end
        end
        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
    end

    // Registers the write channel and the options contents.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            opts <= wosr_pkg::wosr_opts_s'(`WOSR_OPTS_RESET);
            lock <= wosr_pkg::WOSR_OPEN;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            opts <= next_opts;
            lock <= next_lock;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= next_aw_addr;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = `WOSR_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (addr_is(s_axi_araddr, `WOSR_OPTS_OFFSET)) begin
                next_rdata[7:0] = opts & `WOSR_OPTS_IMPL_MASK;
            end else if (addr_is(s_axi_araddr, `WOSR_STATUS_OFFSET)) begin
                next_rdata[`WOSR_STATUS_USED_BIT] = (lock == wosr_pkg::WOSR_LOCKED);
            end else begin
                next_rresp = `WOSR_RESP_SLVERR;
            end
        end
    end

    // Registers the read channel.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ======================================================================
    // Watchdog, stop and pin routing
    logic [2:0] next_period;
    logic next_stop_enter;
    logic next_illegal;
    wosr_pkg::wosr_pair_s next_pa_out;
    wosr_pkg::wosr_pair_s next_pa_oe;
    wosr_pkg::wosr_pair_s next_pb_out;
    wosr_pkg::wosr_pair_s next_pb_oe;
    wosr_pkg::wosr_pair_s next_bus_in;

    // Computes the control outputs from the committed options.
    always_comb begin
        wosr_pkg::wosr_pair_s bus_out;
        wosr_pkg::wosr_pair_s bus_oe;
        wosr_pkg::wosr_pair_s idle;
        bus_out = '{data: serial_data_out, clock: serial_clock_out};
        bus_oe = '{data: serial_data_oe, clock: serial_clock_oe};
        idle = '{data: 1'b0, clock: 1'b0};
        next_period = {watchdog_clock_source_select, opts.wdt_sel};
        next_stop_enter = stop_exec && opts.stop_en;
        next_illegal = stop_exec && !opts.stop_en;
        next_pa_out = opts.pin_sel ? idle : bus_out;
        next_pa_oe = opts.pin_sel ? idle : bus_oe;
        next_pb_out = opts.pin_sel ? bus_out : idle;
        next_pb_oe = opts.pin_sel ? bus_oe : idle;
        next_bus_in.data = opts.pin_sel ? port_b_line_six_in : port_a_line_two_in;
        next_bus_in.clock = opts.pin_sel ? port_b_line_seven_in : port_a_line_three_in;
    end

    // Registers the control outputs so every port comes from a flip-flop.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            watchdog_period_select <= 3'h0;
            stop_mode_enter <= 1'b0;
            illegal_opcode_reset <= 1'b0;
            stop_mode_enable <= 1'b0;
            port_a_line_two_out <= 1'b0;
            port_a_line_three_out <= 1'b0;
            port_a_line_two_oe <= 1'b0;
            port_a_line_three_oe <= 1'b0;
            port_b_line_six_out <= 1'b0;
            port_b_line_seven_out <= 1'b0;
            port_b_line_six_oe <= 1'b0;
            port_b_line_seven_oe <= 1'b0;
            serial_data_in <= 1'b1;
            serial_clock_in <= 1'b1;
        end else begin
            watchdog_period_select <= next_period;
            stop_mode_enter <= next_stop_enter;
            illegal_opcode_reset <= next_illegal;
            stop_mode_enable <= next_opts.stop_en; // tracks the stored bit with no lag.
            port_a_line_two_out <= next_pa_out.data;
            port_a_line_three_out <= next_pa_out.clock;
            port_a_line_two_oe <= next_pa_oe.data;
            port_a_line_three_oe <= next_pa_oe.clock;
            port_b_line_six_out <= next_pb_out.data;
            port_b_line_seven_out <= next_pb_out.clock;
            port_b_line_six_oe <= next_pb_oe.data;
            port_b_line_seven_oe <= next_pb_oe.clock;
            serial_data_in <= next_bus_in.data;
            serial_clock_in <= next_bus_in.clock;
        end
    end

endmodule : wosr_options
`default_nettype wire

// ===== hdl/wosr_pkg.sv
// Purpose: Types shared by the write-once options block.
// Assumes: Field layout matches the header of constants.
// Notes: Reserved fields always hold zero.
package wosr_pkg;

    // ======================================================================
    // Options register layout.
    typedef struct packed {
        logic [1:0] wdt_sel;
        logic stop_en;
        logic [1:0] rsv_hi;
        logic pin_sel;
        logic [1:0] rsv_lo;
    } wosr_opts_s;

    // ======================================================================
    // Write-once lock state, one-hot.
    typedef enum logic [1:0] {
        WOSR_OPEN = 2'b01,
        WOSR_LOCKED = 2'b10
    } wosr_lock_e;

    // ======================================================================
    // Serial bus lines, data and clock as a pair.
    typedef struct packed {
        logic data;
        logic clock;
    } wosr_pair_s;

endpackage : wosr_pkg

// ===== hdl/wosr_regs.svh
// Purpose: Register offsets, field positions and reset values of the write-once options block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
// Notes: Definitions only; included by bare name.
`ifndef WOSR_REGS_SVH
`define WOSR_REGS_SVH

// ==========================================================================
// Register map
`define WOSR_OPTS_OFFSET 8'h00
`define WOSR_STATUS_OFFSET 8'h04

// ==========================================================================
// Options register fields
`define WOSR_WDT_SEL_MSB 7
`define WOSR_WDT_SEL_LSB 6
`define WOSR_STOP_EN_BIT 5
`define WOSR_PIN_SEL_BIT 2
`define WOSR_OPTS_IMPL_MASK 8'he4
`define WOSR_OPTS_RESET 8'hc0

// ==========================================================================
// Status register fields
`define WOSR_STATUS_USED_BIT 0

// ==========================================================================
// Bus responses
`define WOSR_RESP_OKAY 2'b00
`define WOSR_RESP_SLVERR 2'b10

`endif

// ===== tb/wosr_options_assertions.sv
// Purpose: Concurrent checks on the write-once options block ports.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Bound into every wosr_options instance.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker module
module wosr_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic watchdog_clock_source_select,
    input wire logic [2:0] watchdog_period_select,
    input wire logic stop_exec,
    input wire logic stop_mode_enter,
    input wire logic illegal_opcode_reset,
    input wire logic stop_mode_enable,
    input wire logic serial_data_oe,
    input wire logic port_a_line_two_oe,
    input wire logic port_b_line_six_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Steps of a bus transfer as the slave accepts them.
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (wr_both |=> s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed");
    a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4:3] == 2'h0)
        else $error("reserved bits not zero");
    a_stop_locked: assert property (stop_mode_enable |=> stop_mode_enable)
        else $error("locked stop enable changed");
    a_wdt_source: assert property (!$past(rst) |-> watchdog_period_select[2] == $past(watchdog_clock_source_select))
        else $error("timeout clock source bit wrong");
    a_stop_enter: assert property (stop_exec && stop_mode_enable |=> stop_mode_enter && !illegal_opcode_reset)
        else $error("stop mode not entered");
    a_illegal_reset: assert property (stop_exec && !stop_mode_enable |=> illegal_opcode_reset && !stop_mode_enter)
        else $error("illegal opcode reset missing");
    a_pin_route: assert property (port_a_line_two_oe |-> $past(serial_data_oe) && !port_b_line_six_oe)
        else $error("serial data routed wrongly");
endmodule : wosr_checker
bind wosr_options wosr_checker u_chk (.*);
`default_nettype wire

// ===== tb/wosr_options_bench.sv
// Purpose: Self-checking bench for the write-once options block.
// Assumes: AXI4-Lite master tasks start one clock edge after their call.
// Notes: Pin routing is probed with serial output enables held on.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench top
module wosr_options_bench;
    logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [2:0] watchdog_period_select;
    logic watchdog_clock_source_select, stop_exec, stop_mode_enter, illegal_opcode_reset;
    logic stop_mode_enable, serial_data_out, serial_data_oe, serial_clock_out, serial_clock_oe;
    logic serial_data_in, serial_clock_in, port_a_line_two_in, port_a_line_two_out;
    logic port_a_line_two_oe, port_a_line_three_in, port_a_line_three_out, port_a_line_three_oe;
    logic port_b_line_six_in, port_b_line_six_out, port_b_line_six_oe, port_b_line_seven_in;
    logic port_b_line_seven_out, port_b_line_seven_oe;
    logic [31:0] rd;
    int n_mismatch, total_checks, cycles;
    wosr_options #(.ADDR_W(4)) dut (.*);
    // Clock of 25 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset
    // Write: address and data offered together, each released when taken.
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic s);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= {3'h0, s};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        // Late bready makes the response stand one cycle before it is taken.
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        // Late rready makes the read data stand one cycle before it is taken.
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // One stop instruction; expect enter and illegal flags one cycle later.
    task automatic stop_try(input logic [1:0] exp);
        @(posedge sys_clk);
        stop_exec <= 1'b1;
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        #1;
        chk({stop_mode_enter, illegal_opcode_reset}, exp);
    endtask : stop_try
    task automatic t_after_reset();
        axi_rd(4'h0);
        chk(rd, 32'h0000_00c0);
        chk(watchdog_period_select, 3'h7);
        chk({port_a_line_two_oe, port_a_line_two_out, port_b_line_six_oe, serial_data_in}, 4'hc);
        chk({port_a_line_three_oe, port_a_line_three_out, serial_clock_in}, 32'h4);
        chk(stop_mode_enable, 32'h0);
        stop_try(2'h1);
    endtask : t_after_reset
    task automatic t_lane_off();
        axi_wr(4'h0, 8'h3f, 1'b0);
        chk(resp, 32'h0);
        axi_rd(4'h0);
        chk(rd, 32'h0000_00c0);
        chk(resp, 32'h0);
    endtask : t_lane_off
    task automatic t_first_write();
        axi_wr(4'h0, 8'h3f, 1'b1);
        axi_rd(4'h0);
        chk(rd, 32'h0000_0024);
        axi_rd(4'h4);
        chk(rd, 32'h0000_0001);
        chk(watchdog_period_select, 3'h4);
        chk({port_b_line_six_oe, port_b_line_six_out, port_a_line_two_oe,
             port_b_line_seven_oe, serial_data_in}, 5'h1b);
        chk({port_b_line_seven_out, serial_clock_in, port_a_line_three_oe}, 32'h2);
        chk(stop_mode_enable, 32'h1);
        // Drop the clock source, serial drive and pin level, then restore them on an edge.
        {watchdog_clock_source_select, serial_data_out, port_b_line_six_in} <= 3'h0;
        repeat (2) @(posedge sys_clk);
        {watchdog_clock_source_select, serial_data_out, port_b_line_six_in} <= 3'h7;
        #1;
        chk(watchdog_period_select, 32'h0);
        chk({port_b_line_six_out, serial_data_in}, 32'h0);
        stop_try(2'h2);
    endtask : t_first_write
    task automatic t_relock();
        axi_wr(4'h0, 8'hc0, 1'b1);
        chk(resp, 2'h0);
        axi_rd(4'h0);
        chk(rd, 32'h0000_0024);
        axi_wr(4'h8, 8'hff, 1'b1);
        chk(resp, 2'h2);
        axi_rd(4'h8);
        chk(resp, 32'h2);
        chk(rd, 32'h0);
    endtask : t_relock
    // Main sequence.
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = 44'h0;
        {watchdog_clock_source_select, serial_data_out, serial_data_oe} = 3'h7;
        {serial_clock_out, serial_clock_oe, stop_exec, port_a_line_two_in} = 4'h4;
        {port_a_line_three_in, port_b_line_six_in, port_b_line_seven_in} = 3'h3;
        {n_mismatch, total_checks, rst} = 65'h0;
        do_reset();
        t_after_reset();
        t_lane_off();
        t_first_write();
        t_relock();
        do_reset();
        t_after_reset();
        test_done();
    end
endmodule : wosr_options_bench
`default_nettype wire
